// *** common/onoff_pkg.sv ***
// Constants for the on/off, margin and PWM configuration block.
// Assumes a serial front end that delivers whole, decoded commands.
package onoff_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF    = 8'h02;
  localparam logic [7:0] CMD_FREQ      = 8'h33;
  localparam logic [7:0] CMD_GLOBAL    = 8'hd1;
  localparam logic [7:0] CMD_PWM_MODE  = 8'hd4;
  localparam logic [7:0] CMD_PWM_SETUP = 8'hf5;
  localparam logic [7:0] CMD_RESTART   = 8'hfd;
  localparam logic [7:0] PAGE_ALL      = 8'hff;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  OP_RST        = 8'h80;
  localparam logic [7:0]  ONOFF_RST     = 8'h1e;
  localparam logic [15:0] FREQ_RST      = 16'hfabc;
  localparam logic [7:0]  PWM_MODE_RST  = 8'hc2;
  localparam logic [7:0]  PWM_SETUP_RST = 8'h10;
  localparam logic [7:0]  GLOBAL_RST    = 8'h09;
  // ****************************************
  // Operating codes and policies
  // ****************************************
  localparam logic [7:0] OP_OFF         = 8'h00;
  localparam logic [7:0] OP_ON          = 8'h80;
  localparam logic [7:0] OP_MLO         = 8'h98;
  localparam logic [7:0] OP_MHI         = 8'ha8;
  localparam logic [7:0] OP_SEQOFF      = 8'h40;
  localparam logic [7:0] ONOFF_BOTH_IMM = 8'h1f;
  localparam logic [7:0] ONOFF_BOTH_SEQ = 8'h1e;
  localparam logic [7:0] ONOFF_PIN_IMM  = 8'h17;
  localparam logic [7:0] ONOFF_PIN_SEQ  = 8'h19;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int GC_FAULT_LOG   = 7;
  localparam int GC_IGNORE_RCFG = 6;
  localparam int GC_MASK_PLL    = 3;
  localparam int GC_PEC_REQ     = 2;
  localparam int GC_STRETCH     = 1;
  localparam int GC_RUN_CLR     = 0;
  localparam int PM_ILIM        = 7;
  localparam int PM_SERVO       = 6;
  localparam logic [1:0] PWM_DCM   = 2'b00;
  localparam logic [1:0] PWM_BURST = 2'b01;
  localparam logic [1:0] PWM_FCCM  = 2'b10;
  localparam logic [1:0] NB_NONE = 2'd0;
  localparam logic [1:0] NB_BYTE = 2'd1;
  localparam logic [1:0] NB_WORD = 2'd2;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ       = 50;
  localparam int SLEW_STEP_NS  = 1000;
  localparam int SLEW_CYCLES   = (SLEW_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int SERVO_STEP_US = 1000;
  localparam int SERVO_CYCLES  = SERVO_STEP_US * CLK_MHZ;
  localparam int NCH           = 2;
  typedef enum logic [1:0] {
    ST_BOOT   = 2'b00,
    ST_LOAD   = 2'b01,
    ST_ACTIVE = 2'b11
  } boot_state_e;
endpackage : onoff_pkg

// *** verilog/onoff_ctrl.sv ***
// On/off, margin and PWM configuration command handling, two channels.
// Assumes a same-clock front end that hands over whole commands with PEC status.
`timescale 1ns/10ps
module onoff_ctrl
  import onoff_pkg::*;
#(
  parameter int SERVO_TICKS = SERVO_CYCLES,
  parameter int SLEW_TICKS  = SLEW_CYCLES,
  parameter int TRIM_W      = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // Command port
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [7:0]        cmd_code,
  input  wire logic [1:0]        cmd_nbytes,
  input  wire logic [15:0]       cmd_data,
  input  wire logic              cmd_pec_present,
  input  wire logic              cmd_pec_ok,
  input  wire logic [7:0]        page,
  output logic      [15:0]       rd_data,
  output logic                   rd_valid,
  // Pins and sequencer
  input  wire logic [1:0]        run_control_pin,
  input  wire logic [1:0][7:0]   stored_operation,
  input  wire logic [1:0]        ramping_on,
  input  wire logic [1:0][15:0]  vout_nominal,
  input  wire logic [1:0][15:0]  vout_margin_low,
  input  wire logic [1:0][15:0]  vout_margin_high,
  input  wire logic [1:0][15:0]  measured_output_voltage,
  // Channel controls
  output wire logic [1:0]        conv_enable,
  output wire logic [1:0]        off_immediate,
  output wire logic [1:0][1:0]   pwm_mode_eff,
  output wire logic [1:0]        current_limit_range,
  output wire logic [1:0]        servo_active,
  output wire logic [1:0][15:0]  setpoint,
  // Shared controls and events
  output wire logic              fault_log_en,
  output wire logic              ignore_rconfig,
  output wire logic              mask_pll_unlock,
  output wire logic              stretch_allow,
  output wire logic [15:0]       freq_word,
  output wire logic [7:0]        pwm_setup_word,
  output logic                   clear_faults,
  output logic                   cml_fault,
  output logic                   restart
);

  if (TRIM_W < 2 || TRIM_W > 15 || SERVO_TICKS < 1 || SLEW_TICKS < 1) begin : g_bad
    $error("onoff_ctrl: bad parameter");
  end

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic page_hit(input logic [7:0] pg, input int ch);
    return pg == PAGE_ALL || pg == 8'(ch);
  endfunction : page_hit

  function automatic logic cmd_ctl(input logic [7:0] pol);
    return pol == ONOFF_BOTH_IMM || pol == ONOFF_BOTH_SEQ;
  endfunction : cmd_ctl

  function automatic logic op_valid(input logic [7:0] v, input logic pmb);
    return v == OP_ON || v == OP_MLO || v == OP_MHI ||
           (pmb && (v == OP_OFF || v == OP_SEQOFF));
  endfunction : op_valid

  function automatic logic pol_valid(input logic [7:0] v);
    return v == ONOFF_BOTH_IMM || v == ONOFF_BOTH_SEQ ||
           v == ONOFF_PIN_IMM || v == ONOFF_PIN_SEQ;
  endfunction : pol_valid

  // ****************************************
  // State
  // ****************************************
  boot_state_e                 st_r;
  logic [1:0]                  run_meta_r;
  logic [1:0]                  run_sync_r;
  logic [1:0]                  run_prev_r;
  logic [7:0]                  gc_r;
  logic [15:0]                 freq_r;
  logic [7:0]                  setup_r;
  logic [7:0]                  op_r     [NCH];
  logic [7:0]                  pol_r    [NCH];
  logic [7:0]                  pm_r     [NCH];
  logic                        conv_r   [NCH];
  logic                        offimm_r [NCH];
  logic [1:0]                  mode_r   [NCH];
  logic [15:0]                 sp_r     [NCH];
  logic signed [TRIM_W-1:0]    trim_r   [NCH];
  logic [31:0]                 slew_cnt_r;
  logic [31:0]                 servo_cnt_r;
  logic                        slew_tick;
  logic                        servo_tick;
  logic                        active;
  logic                        pec_bad;
  logic                        wr_ok;
  logic                        op_bad;
  logic                        pol_bad;
  logic                        len_bad;
  logic [1:0]                  op_bad_ch;
  logic                        rd_ch;

  assign active = st_r == ST_ACTIVE;
  // Bad PEC, or PEC missing while required, discards the write
  assign pec_bad = cmd_valid && cmd_write && active &&
                   ((cmd_pec_present && !cmd_pec_ok) ||
                    (gc_r[GC_PEC_REQ] && !cmd_pec_present));
  assign wr_ok = cmd_valid && cmd_write && active && !pec_bad && !restart;

  // ****************************************
  // Boot sequence and commanded restart
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_BOOT;
    end else if (clk_en) begin
      case (st_r)
        ST_BOOT:   st_r <= ST_LOAD;
        ST_LOAD:   st_r <= ST_ACTIVE;
        ST_ACTIVE: st_r <= restart ? ST_BOOT : ST_ACTIVE;
        default:   st_r <= ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      restart <= 1'b0;
    end else if (clk_en) begin
      restart <= wr_ok && cmd_code == CMD_RESTART && cmd_nbytes == NB_NONE;
    end
  end

  // ****************************************
  // Run pin synchroniser and edges
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_meta_r <= 2'h0;
      run_sync_r <= 2'h0;
      run_prev_r <= 2'h0;
    end else if (clk_en) begin
      run_meta_r <= run_control_pin;
      run_sync_r <= run_meta_r;
      run_prev_r <= run_sync_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clear_faults <= 1'b0;
    end else if (clk_en) begin
      clear_faults <= gc_r[GC_RUN_CLR] && |(run_sync_r & ~run_prev_r);
    end
  end

  // ****************************************
  // Shared registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gc_r    <= GLOBAL_RST;
      freq_r  <= FREQ_RST;
      setup_r <= PWM_SETUP_RST;
    end else if (clk_en) begin
      if (restart) begin
        gc_r    <= GLOBAL_RST;
        freq_r  <= FREQ_RST;
        setup_r <= PWM_SETUP_RST;
      end else if (wr_ok && !len_bad) begin
        case (cmd_code)
          CMD_GLOBAL:    gc_r <= cmd_data[7:0];
          CMD_FREQ:      freq_r <= cmd_data;
          CMD_PWM_SETUP: setup_r <= cmd_data[7:0];
          default:       gc_r <= gc_r;
        endcase
      end
    end
  end

  assign fault_log_en    = gc_r[GC_FAULT_LOG];
  assign ignore_rconfig  = gc_r[GC_IGNORE_RCFG];
  assign mask_pll_unlock = gc_r[GC_MASK_PLL];
  assign stretch_allow   = gc_r[GC_STRETCH];
  assign freq_word       = freq_r;
  assign pwm_setup_word  = setup_r;

  // ****************************************
  // Write checks and comms fault
  // ****************************************
  always_comb begin
    case (cmd_code)
      CMD_FREQ:    len_bad = cmd_nbytes != NB_WORD;
      CMD_RESTART: len_bad = cmd_nbytes != NB_NONE;
      CMD_OPERATION, CMD_ON_OFF, CMD_GLOBAL, CMD_PWM_MODE, CMD_PWM_SETUP:
                   len_bad = cmd_nbytes != NB_BYTE;
      default:     len_bad = 1'b1;
    endcase
  end

  for (genvar c = 0; c < NCH; c++) begin : g_opchk
    assign op_bad_ch[c] = page_hit(page, c) && !op_valid(cmd_data[7:0], cmd_ctl(pol_r[c]));
  end
  // A page-all write must suit both channels or neither takes it
  assign op_bad  = cmd_code == CMD_OPERATION && |op_bad_ch;
  assign pol_bad = cmd_code == CMD_ON_OFF && !pol_valid(cmd_data[7:0]);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cml_fault <= 1'b0;
    end else if (clk_en) begin
      cml_fault <= pec_bad || (wr_ok && (len_bad || op_bad || pol_bad));
    end
  end

  // ****************************************
  // Slope and servo timers
  // ****************************************
  assign slew_tick  = slew_cnt_r == 32'(SLEW_TICKS - 1);
  assign servo_tick = servo_cnt_r == 32'(SERVO_TICKS - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slew_cnt_r  <= 32'h0;
      servo_cnt_r <= 32'h0;
    end else if (clk_en) begin
      slew_cnt_r  <= slew_tick ? 32'h0 : slew_cnt_r + 32'h1;
      servo_cnt_r <= servo_tick ? 32'h0 : servo_cnt_r + 32'h1;
    end
  end

  // ****************************************
  // Per-channel registers and control
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic        pmb;
    logic        hit;
    logic [15:0] target;
    logic [15:0] goal;

    assign pmb = cmd_ctl(pol_r[c]);
    assign hit = wr_ok && !len_bad && page_hit(page, c);

    always_comb begin
      case (op_r[c])
        OP_MLO:  target = vout_margin_low[c];
        OP_MHI:  target = vout_margin_high[c];
        default: target = vout_nominal[c];
      endcase
    end
    assign goal = target + 16'({{(16 - TRIM_W){trim_r[c][TRIM_W-1]}}, trim_r[c]});

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        op_r[c] <= OP_RST;
      end else if (clk_en) begin
        if (restart) begin
          op_r[c] <= OP_RST;
        end else if (st_r == ST_LOAD) begin
          // Stored margin state comes back after any reset
          if (stored_operation[c] == OP_MLO || stored_operation[c] == OP_MHI) begin
            op_r[c] <= stored_operation[c];
          end
        end else if (hit && cmd_code == CMD_OPERATION && !op_bad) begin
          op_r[c] <= cmd_data[7:0];
        end
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        pol_r[c] <= ONOFF_RST;
        pm_r[c]  <= PWM_MODE_RST;
      end else if (clk_en) begin
        if (restart) begin
          pol_r[c] <= ONOFF_RST;
          pm_r[c]  <= PWM_MODE_RST;
        end else if (hit && cmd_code == CMD_ON_OFF && !pol_bad) begin
          pol_r[c] <= cmd_data[7:0];
        end else if (hit && cmd_code == CMD_PWM_MODE) begin
          pm_r[c] <= cmd_data[7:0];
        end
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        conv_r[c]   <= 1'b0;
        offimm_r[c] <= 1'b1;
        mode_r[c]   <= PWM_DCM;
      end else if (clk_en) begin
        // Pin always gates; command gates only under 1F/1E
        conv_r[c] <= active && run_sync_r[c] &&
                     (!pmb || op_r[c] == OP_ON || op_r[c] == OP_MLO ||
                      op_r[c] == OP_MHI);
        offimm_r[c] <= pol_r[c] == ONOFF_BOTH_IMM || pol_r[c] == ONOFF_PIN_IMM ||
                       (pmb && op_r[c] == OP_OFF);
        mode_r[c] <= ramping_on[c] ? PWM_DCM : pm_r[c][1:0];
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        trim_r[c] <= '0;
      end else if (clk_en) begin
        if (restart) begin
          trim_r[c] <= '0;
        end else if (!servo_active[c]) begin
          trim_r[c] <= trim_r[c];
        end else if (servo_tick && measured_output_voltage[c] < target &&
                     trim_r[c] != {1'b0, {(TRIM_W - 1){1'b1}}}) begin
          trim_r[c] <= trim_r[c] + TRIM_W'(1);
        end else if (servo_tick && measured_output_voltage[c] > target &&
                     trim_r[c] != {1'b1, {(TRIM_W - 1){1'b0}}}) begin
          trim_r[c] <= trim_r[c] - TRIM_W'(1);
        end
      end
    end

    // One code step per slope tick; trades speed for a predictable slew
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        sp_r[c] <= 16'h0;
      end else if (clk_en && restart) begin
        sp_r[c] <= 16'h0;
      end else if (clk_en && slew_tick) begin
        if (sp_r[c] < goal) begin
          sp_r[c] <= sp_r[c] + 16'h1;
        end else if (sp_r[c] > goal) begin
          sp_r[c] <= sp_r[c] - 16'h1;
        end
      end
    end

    assign conv_enable[c]         = conv_r[c];
    assign off_immediate[c]       = offimm_r[c];
    assign pwm_mode_eff[c]        = mode_r[c];
    assign current_limit_range[c] = pm_r[c][PM_ILIM];
    assign servo_active[c]        = pm_r[c][PM_SERVO] && conv_r[c] && !ramping_on[c];
    assign setpoint[c]            = sp_r[c];
  end

  // ****************************************
  // Read answers
  // ****************************************
  assign rd_ch = page == 8'h01;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0;
    end else if (clk_en) begin
      rd_valid <= cmd_valid && !cmd_write && active;
      case (cmd_code)
        CMD_OPERATION: rd_data <= {8'h0, op_r[rd_ch]};
        CMD_ON_OFF:    rd_data <= {8'h0, pol_r[rd_ch]};
        CMD_PWM_MODE:  rd_data <= {8'h0, pm_r[rd_ch]};
        CMD_GLOBAL:    rd_data <= {8'h0, gc_r};
        CMD_PWM_SETUP: rd_data <= {8'h0, setup_r};
        CMD_FREQ:      rd_data <= freq_r;
        default:       rd_data <= 16'h0;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_bad_pec_op;
    clk_en && cmd_valid && cmd_write && active && !restart &&
    cmd_pec_present && !cmd_pec_ok && cmd_code == CMD_OPERATION;
  endsequence
  sequence s_unpec_op;
    clk_en && cmd_valid && cmd_write && active && !restart &&
    gc_r[GC_PEC_REQ] && !cmd_pec_present && cmd_code == CMD_OPERATION;
  endsequence

  a_run_low_stop: assert property (clk_en && !run_sync_r[0] |=> !conv_enable[0])
    else $error("channel 0 converts with run pin low");
  a_bad_pec_drop: assert property (s_bad_pec_op |=> cml_fault && $stable(op_r[0]))
    else $error("bad PEC write not discarded");
  a_pec_needed: assert property (s_unpec_op |=> $stable(op_r[0]) && $stable(op_r[1]))
    else $error("write without PEC accepted");
  a_bad_policy: assert property (wr_ok && clk_en && cmd_code == CMD_ON_OFF && pol_bad &&
                                 cmd_nbytes == NB_BYTE |=> cml_fault && $stable(pol_r[0]))
    else $error("unsupported policy taken");
  a_ramp_dcm: assert property (clk_en && ramping_on[0] |=> pwm_mode_eff[0] == PWM_DCM)
    else $error("ramp not discontinuous");
  a_run_clear: assert property (clk_en && gc_r[GC_RUN_CLR] && run_sync_r[1] &&
                                !run_prev_r[1] |=> clear_faults)
    else $error("run edge did not clear faults");
  a_restart_vals: assert property (clk_en && restart |=> op_r[0] == OP_RST &&
                                   pol_r[1] == ONOFF_RST && gc_r == GLOBAL_RST)
    else $error("restart left state");
  a_trim_hold: assert property (ramping_on[0] |=> $stable(trim_r[0]))
    else $error("trim moved while ramping");
  a_pin_only_on: assert property (clk_en && active && pol_r[0] == ONOFF_PIN_IMM &&
                                  run_sync_r[0] |=> conv_enable[0])
    else $error("pin-only policy ignored pin");
  a_pol_reset: assert property (clk_en && $rose(st_r == ST_LOAD) |-> pol_r[0] == ONOFF_RST)
    else $error("policy reset value wrong");

endmodule : onoff_ctrl

// *** verification/host_model.sv ***
// Bus host stand-in driving whole decoded commands into the block.
// Assumes the block samples its command port on rising clk.
`timescale 1ns/10ps
module host_model (
  // Clock
  input  wire logic        clk,
  // Command port
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [1:0]       cmd_nbytes,
  output logic [15:0]      cmd_data,
  output logic             cmd_pec_present,
  output logic             cmd_pec_ok
);
  initial {cmd_valid, cmd_write, cmd_code, cmd_nbytes, cmd_data, cmd_pec_present, cmd_pec_ok} = '0;
  // Held for exactly one taken edge; restart goes as send-byte, nb 0
  task automatic send(input logic w, input logic [7:0] c, input logic [1:0] nb,
                      input logic [15:0] d, input logic pp, input logic pk);
    @(posedge clk);
    #2;
    {cmd_valid, cmd_write, cmd_code, cmd_nbytes, cmd_data, cmd_pec_present, cmd_pec_ok} = {1'b1, w, c, nb, d, pp, pk};
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    // Released data no longer shows the last value
    cmd_data  = ~cmd_data;
  endtask : send
endmodule : host_model

// *** verification/tb_top.sv ***
// Self-checking bench for the on/off and PWM configuration block.
// Assumes host_model drives the command port; slopes shortened.
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  import onoff_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, cmd_valid, cmd_write, cmd_pec_present, cmd_pec_ok;
  logic [7:0] cmd_code, page = 8'h00, g, cur_op;
  logic [1:0] cmd_nbytes, run = 2'b00, ramp = 2'b00, cv, oi, clr, sa;
  logic [15:0] cmd_data, rd_data;
  logic [1:0][7:0] stored = '0;
  logic [1:0][15:0] vnom = '0, vlo = '0, sp;
  logic [1:0][1:0] pme;
  logic rd_valid, cf, flt, rst, fle, irc, mpl, sta;
  logic [31:0] seed = 32'd91;
  int mismatches = 0, cmp_count = 0, k;
  logic [7:0] pols [4] = '{ONOFF_BOTH_IMM, ONOFF_BOTH_SEQ, ONOFF_PIN_IMM, ONOFF_PIN_SEQ};
  logic [7:0] ops [5] = '{OP_ON, OP_MLO, OP_MHI, OP_SEQOFF, OP_OFF};
  always #10 clk = ~clk;
  host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_nbytes(cmd_nbytes), .cmd_data(cmd_data), .cmd_pec_present(cmd_pec_present), .cmd_pec_ok(cmd_pec_ok));
  onoff_ctrl #(.SERVO_TICKS(8), .SLEW_TICKS(2)) i_onoff_ctrl (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_nbytes(cmd_nbytes),
    .cmd_data(cmd_data), .cmd_pec_present(cmd_pec_present), .cmd_pec_ok(cmd_pec_ok), .page(page),
    .rd_data(rd_data), .rd_valid(rd_valid), .run_control_pin(run), .stored_operation(stored),
    .ramping_on(ramp), .vout_nominal(vnom), .vout_margin_low(vlo), .vout_margin_high('0),
    .measured_output_voltage('0), .conv_enable(cv), .off_immediate(oi), .pwm_mode_eff(pme),
    .current_limit_range(clr), .servo_active(sa), .setpoint(sp), .fault_log_en(fle),
    .ignore_rconfig(irc), .mask_pll_unlock(mpl), .stretch_allow(sta), .freq_word(),
    .pwm_setup_word(), .clear_faults(cf), .cml_fault(flt), .restart(rst));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic exp_conv(input logic [7:0] pol, input logic [7:0] op, input logic pin);
    if (!pin) return 1'b0;
    if (pol == ONOFF_PIN_IMM || pol == ONOFF_PIN_SEQ) return 1'b1;
    return op != OP_OFF && op != OP_SEQOFF;
  endfunction : exp_conv
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic pp = 1'b0, input logic pk = 1'b0);
    u_host.send(1'b1, c, (c == CMD_FREQ) ? NB_WORD : NB_BYTE, d, pp, pk);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    u_host.send(1'b0, c, NB_NONE, 16'h0000, 1'b0, 1'b0);
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", e, rd_data)
  endtask : rd
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : edges
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  initial begin
    edges(3);
    reset_n = 1'b1;
    edges(3);
    // ****************************************
    // Defaults
    // ****************************************
    rd(CMD_OPERATION, 16'h0080);
    rd(CMD_ON_OFF, 16'h001e);
    rd(CMD_FREQ, 16'hfabc);
    rd(CMD_GLOBAL, 16'h0009);
    $display("defaults done");
    // Random global byte, PEC demanded
    g = rnd() | 8'h05;
    wr(CMD_GLOBAL, {8'h00, g}, 1'b1, 1'b1);
    `CHK("globals", {g[7], g[6], g[3], g[1]}, {fle, irc, mpl, sta})
    wr(CMD_PWM_MODE, 16'h0001);
    `CHK("no pec", 1'b1, flt)
    wr(CMD_PWM_MODE, 16'h0001, 1'b1, 1'b0);
    `CHK("bad pec", 1'b1, flt)
    rd(CMD_PWM_MODE, 16'h00c2);
    g = g & 8'hfb;
    wr(CMD_GLOBAL, {8'h00, g}, 1'b1, 1'b1);
    `CHK("good pec", 1'b0, flt)
    wr(CMD_ON_OFF, 16'h0033);
    `CHK("bad policy", 1'b1, flt)
    rd(CMD_ON_OFF, 16'h001e);
    $display("pec done");
    // ****************************************
    // Policies and operating codes, pins high; then run pin low and rising run edge
    // ****************************************
    run = 2'b11;
    cur_op = OP_ON;
    edges(4);
    foreach (pols[i]) begin
      wr(CMD_ON_OFF, {8'h00, pols[i]});
      foreach (ops[j]) begin
        k = int'((pols[i] == ONOFF_PIN_IMM || pols[i] == ONOFF_PIN_SEQ) && (ops[j] == OP_OFF || ops[j] == OP_SEQOFF));
        wr(CMD_OPERATION, {8'h00, ops[j]});
        `CHK("op fault", k[0], flt)
        if (k == 0) cur_op = ops[j];
        edges(1);
        `CHK("conv", exp_conv(pols[i], cur_op, 1'b1), cv[0])
        if (cv[0] === 1'b1) `CHK("off imm", pols[i] == ONOFF_BOTH_IMM || pols[i] == ONOFF_PIN_IMM, oi[0])
      end
    end
    page = 8'h01;
    wr(CMD_OPERATION, {8'h00, OP_OFF});
    edges(1);
    `CHK("page conv", 2'b01, cv)
    run[0] = 1'b0;
    edges(4);
    `CHK("pin low", 1'b0, cv[0])
    run[1] = 1'b0;
    edges(4);
    run[1] = 1'b1;
    k = 0;
    repeat (6) begin
      edges(1);
      if (cf === 1'b1) k++;
    end
    `CHK("clear pulses", 1, k)
    $display("onoff done");
    // ****************************************
    // PWM mode
    // ****************************************
    page = 8'h00;
    for (int m = 0; m < 3; m++) begin
      g = {rnd() & 8'hc0} | 8'(m);
      wr(CMD_PWM_MODE, {8'h00, g});
      edges(2);
      `CHK("pwm mode", g[1:0], pme[0])
      `CHK("ilim", g[7], clr[0])
    end
    ramp[0] = 1'b1;
    edges(2);
    `CHK("ramp mode", PWM_DCM, pme[0])
    `CHK("servo", 1'b0, sa[0])
    ramp[0] = 1'b0;
    $display("pwm done");
    // Restart with a stored margin code on channel 0
    stored = {OP_ON, OP_MLO};
    u_host.send(1'b1, CMD_RESTART, NB_NONE, 16'h0000, 1'b0, 1'b0);
    `CHK("restart", 1'b1, rst)
    edges(4);
    rd(CMD_OPERATION, {8'h00, OP_MLO});
    rd(CMD_PWM_MODE, 16'h00c2);
    $display("restart done");
    // Servo on margin-low target; measured reads zero, so trim must climb
    run = 2'b11;
    vlo[0] = 16'h0010;
    edges(200);
    `CHK("servo on", 1'b1, sa[0])
    `CHK("trim up", 1'b1, sp[0] > 16'h0010)
    $display("servo done");
    end_sim();
  end
endmodule : tb_top
